/* File: pkg/uaam_pkg.sv */
// Purpose: Shared constants for the receive address filter of the serial port.
// Assumes: An 8-bit special-function register space reached over a plain port.
// Notes:   Every offset and field position is named here once; reset values are named for all but the flag, ninth-bit, read-data and irq registers.

// ============================================================================
// Package
// ============================================================================
package uaam_pkg;

	// Receive modes of the serial port, in their hardware encoding.
	typedef enum logic [1:0] {
		UAAM_MODE_SHIFT,
		UAAM_MODE_ASYNC8,
		UAAM_MODE_ASYNC9_FIX,
		UAAM_MODE_ASYNC9_VAR
	} uaam_mode_t;

	// Register offsets.
	localparam logic [7:0] UAAM_OFS_CTRL      = 8'h98;
	localparam logic [7:0] UAAM_OFS_RXBUF     = 8'h99;
	localparam logic [7:0] UAAM_OFS_OWN_ADDR  = 8'hA9;
	localparam logic [7:0] UAAM_OFS_ADDR_MASK = 8'hB9;
	localparam logic [7:0] UAAM_OFS_INT_STAT  = 8'hC0;
	localparam logic [7:0] UAAM_OFS_INT_MASK  = 8'hC1;

	// Control register fields.
	localparam int UAAM_CTRL_RCF_BIT  = 0;
	localparam int UAAM_CTRL_R9_BIT   = 2;
	localparam int UAAM_CTRL_MPE_BIT  = 5;
	localparam int UAAM_CTRL_MODE_LSB = 6;

	// Interrupt status and mask fields.
	localparam int UAAM_INT_W        = 3;
	localparam int UAAM_INT_ACC_BIT  = 0;
	localparam int UAAM_INT_DROP_BIT = 1;
	localparam int UAAM_INT_OVR_BIT  = 2;

	// Reset values.
	localparam logic [7:0]            UAAM_OWN_ADDR_RST  = 8'h00;
	localparam logic [7:0]            UAAM_ADDR_MASK_RST = 8'h00;
	localparam logic [7:0]            UAAM_RXBUF_RST     = 8'h00;
	localparam logic [UAAM_INT_W-1:0] UAAM_INT_RST       = 3'h0;
	localparam logic                  UAAM_MPE_RST       = 1'b0;
	localparam uaam_mode_t            UAAM_MODE_RST      = UAAM_MODE_SHIFT;

endpackage

/* File: core/uaam_match.sv */
// Purpose: Address comparator for the receive address filter.
// Assumes: Pure combinational logic fed from registers of the same clock.
// Notes:   Reports the given-address and broadcast-address hits separately.

`timescale 1ns/1ps

// ============================================================================
// Comparator
// ============================================================================
module uaam_match
	import uaam_pkg::*;
(
	input  wire logic [7:0] rx_byte,   // Received address byte.
	input  wire logic [7:0] own_addr,  // Own slave address.
	input  wire logic [7:0] addr_mask, // Slave address mask.
	output logic            given_hit, // Byte matches the given address.
	output logic            bcast_hit  // Byte matches the broadcast address.
);

	// True when every significant bit of the byte equals the pattern bit.
	function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] care);
		masked_eq = ((a ^ b) & care) == 8'h00;
	endfunction

	logic [7:0] bcast_pat;

	// Ones of the OR are significant and must be received as ones.
	assign bcast_pat = own_addr | addr_mask;
	assign given_hit = masked_eq(rx_byte, own_addr, addr_mask);
	assign bcast_hit = masked_eq(rx_byte, bcast_pat, bcast_pat);

endmodule // uaam_match

/* File: core/uaam_filter.sv */
// Purpose: Receive-path address filter and receive-complete logic of a UART.
// Assumes: Frames come from the receive shifter on the same clock as a pulse.
// Notes:   frame_bit9 is the ninth bit in 9-bit modes and the stop bit in mode 1.

`timescale 1ns/1ps

// ============================================================================
// Filter top
// ============================================================================
module uaam_filter
	import uaam_pkg::*;
(
	input  wire logic       clk_sys,               // System clock, 10 MHz.
	input  wire logic       arst_n,                // Asynchronous reset, active low.
	input  wire logic [7:0] reg_addr,              // Register address.
	input  wire logic [7:0] reg_wdata,             // Register write data.
	input  wire logic       reg_wr,                // Write strobe.
	input  wire logic       reg_rd,                // Read strobe.
	output logic      [7:0] reg_rdata,             // Read data, cycle after strobe.
	input  wire logic       frame_valid,           // One-cycle pulse: frame received.
	input  wire logic [7:0] frame_data,            // Received byte.
	input  wire logic       frame_bit9,            // Ninth bit, or stop bit in mode 1.
	output logic            receive_complete_flag, // Receive-complete flag.
	output logic      [7:0] serial_rx_buffer,      // Accepted receive byte.
	output logic            irq                    // Level interrupt.
);

	// ========================================================================
	// Registers
	// ========================================================================
	logic [7:0]            own_slave_address_reg;
	logic [7:0]            slave_address_mask_reg;
	logic                  rcf_reg;
	logic                  received_ninth_bit_reg;
	logic [7:0]            rxbuf_reg;
	logic                  multiproc_enable_reg;
	uaam_mode_t            mode_reg;
	logic [UAAM_INT_W-1:0] int_stat_reg;
	logic [UAAM_INT_W-1:0] int_mask_reg;
	logic [UAAM_INT_W-1:0] int_stat_next;
	logic [UAAM_INT_W-1:0] int_mask_next;
	logic [7:0]            rdata_reg;
	logic                  irq_reg;

	logic                  given_hit;
	logic                  bcast_hit;
	logic                  addr_hit;
	logic                  frame_ok;
	logic                  accept;
	logic                  drop;
	logic                  overrun;
	logic                  wr_ctrl;
	logic                  rd_stat;

	assign wr_ctrl = reg_wr && (reg_addr == UAAM_OFS_CTRL);
	assign rd_stat = reg_rd && (reg_addr == UAAM_OFS_INT_STAT);

	// ========================================================================
	// Address comparison
	// ========================================================================
	uaam_match u_match (
		.rx_byte   (frame_data),
		.own_addr  (own_slave_address_reg),
		.addr_mask (slave_address_mask_reg),
		.given_hit (given_hit),
		.bcast_hit (bcast_hit)
	);

	assign addr_hit = given_hit || bcast_hit;

	// ========================================================================
	// Frame qualification
	// ========================================================================
	always_comb begin
		if (mode_reg == UAAM_MODE_SHIFT) begin
			frame_ok = 1'b1;
		end else if (!multiproc_enable_reg) begin
			frame_ok = 1'b1;
		end else begin
			// In mode 1 frame_bit9 is the stop bit, so a bad stop also drops it.
			frame_ok = frame_bit9 && addr_hit;
		end
	end

	assign accept  = frame_valid && !rcf_reg && frame_ok;
	assign drop    = frame_valid && !rcf_reg && !frame_ok;
	assign overrun = frame_valid && rcf_reg;

	// ========================================================================
	// Address and mask registers
	// ========================================================================
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			own_slave_address_reg <= UAAM_OWN_ADDR_RST;
		end else if (reg_wr && reg_addr == UAAM_OFS_OWN_ADDR) begin
			own_slave_address_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			slave_address_mask_reg <= UAAM_ADDR_MASK_RST;
		end else if (reg_wr && reg_addr == UAAM_OFS_ADDR_MASK) begin
			slave_address_mask_reg <= reg_wdata;
		end
	end

	// ========================================================================
	// Control register
	// ========================================================================
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			multiproc_enable_reg <= UAAM_MPE_RST;
			mode_reg             <= UAAM_MODE_RST;
		end else if (wr_ctrl) begin
			multiproc_enable_reg <= reg_wdata[UAAM_CTRL_MPE_BIT];
			mode_reg             <= uaam_mode_t'(reg_wdata[UAAM_CTRL_MODE_LSB +: 2]);
		end
	end

	// A frame accepted in the same cycle as a clearing write keeps the flag set.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rcf_reg <= 1'b0;
		end else if (accept) begin
			rcf_reg <= 1'b1;
		end else if (wr_ctrl && !reg_wdata[UAAM_CTRL_RCF_BIT]) begin
			rcf_reg <= 1'b0;
		end
	end

	// ========================================================================
	// Receive buffer
	// ========================================================================
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rxbuf_reg              <= UAAM_RXBUF_RST;
			received_ninth_bit_reg <= 1'b0;
		end else if (accept) begin
			rxbuf_reg <= frame_data;
			if (mode_reg != UAAM_MODE_SHIFT) begin
				received_ninth_bit_reg <= frame_bit9;
			end
		end
	end

	// ========================================================================
	// Interrupt status and mask
	// ========================================================================
	always_comb begin
		int_stat_next = int_stat_reg;
		if (rd_stat) begin
			int_stat_next = UAAM_INT_RST;
		end
		int_stat_next[UAAM_INT_ACC_BIT]  = int_stat_next[UAAM_INT_ACC_BIT] | accept;
		int_stat_next[UAAM_INT_DROP_BIT] = int_stat_next[UAAM_INT_DROP_BIT] | drop;
		int_stat_next[UAAM_INT_OVR_BIT]  = int_stat_next[UAAM_INT_OVR_BIT] | overrun;
	end

	always_comb begin
		int_mask_next = int_mask_reg;
		if (reg_wr && reg_addr == UAAM_OFS_INT_MASK) begin
			int_mask_next = reg_wdata[UAAM_INT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			int_stat_reg <= UAAM_INT_RST;
			int_mask_reg <= UAAM_INT_RST;
		end else begin
			int_stat_reg <= int_stat_next;
			int_mask_reg <= int_mask_next;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(int_stat_next & int_mask_next);
		end
	end

	// ========================================================================
	// Read data
	// ========================================================================
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				UAAM_OFS_OWN_ADDR:  rdata_reg <= own_slave_address_reg;
				UAAM_OFS_ADDR_MASK: rdata_reg <= slave_address_mask_reg;
				UAAM_OFS_RXBUF:    rdata_reg <= rxbuf_reg;
				UAAM_OFS_INT_STAT: rdata_reg <= {5'h00, int_stat_reg};
				UAAM_OFS_INT_MASK: rdata_reg <= {5'h00, int_mask_reg};
				UAAM_OFS_CTRL: begin
					rdata_reg                         <= 8'h00;
					rdata_reg[UAAM_CTRL_MODE_LSB +: 2] <= mode_reg;
					rdata_reg[UAAM_CTRL_MPE_BIT]      <= multiproc_enable_reg;
					rdata_reg[UAAM_CTRL_R9_BIT]       <= received_ninth_bit_reg;
					rdata_reg[UAAM_CTRL_RCF_BIT]      <= rcf_reg;
				end
				default:           rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata             = rdata_reg;
	assign receive_complete_flag = rcf_reg;
	assign serial_rx_buffer      = rxbuf_reg;
	assign irq                   = irq_reg;

	// ========================================================================
	// Assertions
	// ========================================================================
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	logic filt_on;
	assign filt_on = multiproc_enable_reg && (mode_reg != UAAM_MODE_SHIFT);

	sequence s_free_frame;
		frame_valid && !rcf_reg;
	endsequence

	sequence s_flag_loaded;
		rcf_reg && (serial_rx_buffer == $past(frame_data));
	endsequence

	property p_miss_no_flag;
		s_free_frame and (filt_on && !addr_hit) |=> !rcf_reg;
	endproperty
	a_miss_no_flag: assert property (p_miss_no_flag)
		else $error("Flag raised for an address that did not match.");

	property p_filter_off_accepts;
		s_free_frame and !multiproc_enable_reg |=> s_flag_loaded;
	endproperty
	a_filter_off_accepts: assert property (p_filter_off_accepts)
		else $error("Frame not accepted with filtering off.");

	property p_mode1_bad_stop;
		s_free_frame and (multiproc_enable_reg && mode_reg == UAAM_MODE_ASYNC8
			&& !frame_bit9) |=> !rcf_reg;
	endproperty
	a_mode1_bad_stop: assert property (p_mode1_bad_stop)
		else $error("Mode 1 frame with bad stop bit raised the flag.");

	property p_given_accept;
		s_free_frame and (frame_bit9 && ((frame_data & slave_address_mask_reg)
			== (own_slave_address_reg & slave_address_mask_reg))) |=> s_flag_loaded;
	endproperty
	a_given_accept: assert property (p_given_accept)
		else $error("Given address hit was not accepted.");

	property p_bcast_accept;
		s_free_frame and (frame_bit9 && ((frame_data & (own_slave_address_reg
			| slave_address_mask_reg)) == (own_slave_address_reg
			| slave_address_mask_reg))) |=> s_flag_loaded;
	endproperty
	a_bcast_accept: assert property (p_bcast_accept)
		else $error("Broadcast address hit was not accepted.");

	property p_open_after_reset;
		$rose(arst_n) |-> own_slave_address_reg == 8'h00 && slave_address_mask_reg == 8'h00;
	endproperty
	a_open_after_reset: assert property (p_open_after_reset)
		else $error("Address or mask not cleared by reset.");

	property p_own_addr_readback;
		reg_rd && reg_addr == UAAM_OFS_OWN_ADDR |=> reg_rdata == $past(own_slave_address_reg);
	endproperty
	a_own_addr_readback: assert property (p_own_addr_readback)
		else $error("Own address read back wrong.");

	property p_mask_write;
		reg_wr && reg_addr == UAAM_OFS_ADDR_MASK ##1 reg_rd && reg_addr == UAAM_OFS_ADDR_MASK
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("Mask write not seen on read back.");

	property p_full_holds_buffer;
		frame_valid && rcf_reg |=> $stable(serial_rx_buffer) && rcf_reg;
	endproperty
	a_full_holds_buffer: assert property (p_full_holds_buffer)
		else $error("Buffer loaded while the flag was set.");

	property p_data_frame_ignored;
		s_free_frame and (filt_on && !frame_bit9) |=> !rcf_reg && $stable(serial_rx_buffer);
	endproperty
	a_data_frame_ignored: assert property (p_data_frame_ignored)
		else $error("Data frame accepted with multiprocessor mode on.");

	property p_irq_follows;
		accept && int_mask_reg[UAAM_INT_ACC_BIT] && !(reg_wr && reg_addr == UAAM_OFS_INT_MASK)
			|=> irq && int_stat_reg[UAAM_INT_ACC_BIT];
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("Unmasked accept did not raise the interrupt.");

	property p_drop_status;
		s_free_frame and (filt_on && !frame_bit9) |=> int_stat_reg[UAAM_INT_DROP_BIT];
	endproperty
	a_drop_status: assert property (p_drop_status)
		else $error("Ignored data frame did not set the drop status bit.");

	property p_overrun_status;
		frame_valid && rcf_reg |=> int_stat_reg[UAAM_INT_OVR_BIT];
	endproperty
	a_overrun_status: assert property (p_overrun_status)
		else $error("Frame while the flag was set did not set the overrun bit.");

	property p_stat_read_clears;
		rd_stat && !frame_valid |=> int_stat_reg == UAAM_INT_RST;
	endproperty
	a_stat_read_clears: assert property (p_stat_read_clears)
		else $error("Status read did not clear the status bits.");

	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("Read data not zero outside a read.");

endmodule // uaam_filter

/* File: tb/uaam_master_node.sv */
// Purpose: Master node model that hands received frames to the address filter.
// Assumes: Frames arrive already deserialised, one pulse each on the system clock.
// Notes:   Outside a frame the data lines carry the inverse of the last frame.

`timescale 1ns/1ps

// ============================================================================
// Master node
// ============================================================================
module uaam_master_node (
	input  wire logic       clk_sys,     // System clock.
	output logic            frame_valid, // One-cycle frame pulse.
	output logic      [7:0] frame_data,  // Address or data byte.
	output logic            frame_bit9   // Ninth bit, or stop bit in mode 1.
);
	initial begin
		frame_valid = 1'b0;
		frame_data  = 8'h00;
		frame_bit9  = 1'b0;
	end

	// Sends one frame after some idle cycles; the caller picks address bits that
	// exclude or group slaves, and bit9 high marks an address frame.
	task automatic send_frame(input logic [7:0] d, input logic b9, input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		frame_valid <= 1'b1;
		frame_data  <= d;
		frame_bit9  <= b9;
		@(posedge clk_sys);
		frame_valid <= 1'b0;
		frame_data  <= ~d;
		frame_bit9  <= ~b9;
	endtask
endmodule // uaam_master_node

/* File: tb/uart_auto_address_match_tb.sv */
// Purpose: Self-checking bench of the receive address filter.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Each frame is followed by a status read, which also clears it.

`timescale 1ns/1ps

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end

// ============================================================================
// Bench top
// ============================================================================
module uart_auto_address_match_tb
	import uaam_pkg::*;
;
	logic       clk_sys   = 1'b0;
	logic       arst_n    = 1'b0;
	logic [7:0] reg_addr  = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] serial_rx_buffer;
	logic       receive_complete_flag;
	logic       irq;
	logic       frame_valid;
	logic [7:0] frame_data;
	logic       frame_bit9;
	logic [2:0] msk       = 3'h0;
	logic       exp_flag  = 1'b0;
	logic [7:0] last_buf  = 8'h00;
	logic [7:0] addr_tab [6] = '{8'hC2, 8'hC1, 8'hC0, 8'hFF, 8'hFE, 8'hC4};
	logic       hit_tab  [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	int         n_mismatch  = 0;
	int         comparisons = 0;

	always #50 clk_sys = ~clk_sys;

	uaam_filter dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
		.frame_data(frame_data), .frame_bit9(frame_bit9),
		.receive_complete_flag(receive_complete_flag),
		.serial_rx_buffer(serial_rx_buffer), .irq(irq)
	);

	uaam_master_node u_master (
		.clk_sys(clk_sys), .frame_valid(frame_valid), .frame_data(frame_data),
		.frame_bit9(frame_bit9)
	);

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_check(input logic [7:0] a, input logic [7:0] ex);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", ex, reg_rdata)
	endtask

	// Writes a register and reads it back in the very next cycle.
	task automatic reg_write_check(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", d, reg_rdata)
	endtask

	// Writing the control register with bit 0 low also clears the flag.
	task automatic set_ctrl(input logic [7:0] v);
		reg_write(UAAM_OFS_CTRL, v);
		exp_flag = 1'b0;
	endtask

	// A frame that passes the filter is refused while the flag is still set.
	task automatic frame_chk(input logic [7:0] d, input logic b9, input logic pass);
		logic [2:0] st;
		st = exp_flag ? 3'h4 : (pass ? 3'h1 : 3'h2);
		u_master.send_frame(d, b9, 0);
		#1;
		if (pass && !exp_flag) begin
			exp_flag = 1'b1;
			last_buf = d;
		end
		`CHK("flag", exp_flag, receive_complete_flag)
		`CHK("buffer", last_buf, serial_rx_buffer)
		`CHK("irq", |(st & msk), irq)
		reg_check(UAAM_OFS_INT_STAT, {5'h00, st});
		`CHK("irq", 1'b0, irq)
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge clk_sys);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		reg_check(UAAM_OFS_OWN_ADDR, 8'h00);
		reg_check(UAAM_OFS_ADDR_MASK, 8'h00);
		reg_check(UAAM_OFS_INT_STAT, 8'h00);
		reg_check(8'h55, 8'h00);
		reg_write(UAAM_OFS_OWN_ADDR, 8'h5A);
		reg_write_check(UAAM_OFS_ADDR_MASK, 8'hA5);
		reg_check(UAAM_OFS_OWN_ADDR, 8'h5A);
		reg_check(UAAM_OFS_ADDR_MASK, 8'hA5);
		reg_write(UAAM_OFS_OWN_ADDR, 8'h00);
		reg_write(UAAM_OFS_ADDR_MASK, 8'h00);
		reg_write(UAAM_OFS_INT_MASK, 8'h07);
		msk = 3'h7;
		reg_check(UAAM_OFS_INT_MASK, 8'h07);
		set_ctrl(8'hE0);
		frame_chk(8'h3C, 1'b1, 1'b1);
		set_ctrl(8'hE0);
		frame_chk(8'h3C, 1'b0, 1'b0);
		reg_write(UAAM_OFS_OWN_ADDR, 8'hC0);
		reg_write(UAAM_OFS_ADDR_MASK, 8'hFD);
		for (int i = 0; i < 6; i++) begin
			frame_chk(addr_tab[i], 1'b1, hit_tab[i]);
			set_ctrl(8'hE0);
		end
		frame_chk(8'hC0, 1'b1, 1'b1);
		frame_chk(8'hFF, 1'b1, 1'b1);
		set_ctrl(8'h60);
		frame_chk(8'hC0, 1'b0, 1'b0);
		frame_chk(8'hC0, 1'b1, 1'b1);
		reg_check(UAAM_OFS_CTRL, 8'h65);
		set_ctrl(8'h60);
		frame_chk(8'hC1, 1'b1, 1'b0);
		set_ctrl(8'hC0);
		frame_chk(8'hC1, 1'b0, 1'b1);
		set_ctrl(8'hC0);
		reg_write(UAAM_OFS_INT_MASK, 8'h00);
		msk = 3'h0;
		frame_chk(8'hC1, 1'b0, 1'b1);
		reg_write(UAAM_OFS_INT_MASK, 8'h02);
		msk = 3'h2;
		// Shift mode ignores the enable bit and keeps the stored ninth bit.
		set_ctrl(8'h20);
		frame_chk(8'hC1, 1'b1, 1'b1);
		reg_check(UAAM_OFS_CTRL, 8'h21);
		set_ctrl(8'hA0);
		frame_chk(8'hC1, 1'b1, 1'b0);
		give_verdict();
	end
endmodule // uart_auto_address_match_tb
